// >>> wiper_pkg.sv
// constants shared by the quad wiper latch loader
package wiper_pkg;
  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int          WORD_BITS  = 10;         // address plus data bits
  localparam int          ADDR_HI    = 9;          // address field msb
  localparam int          ADDR_LO    = 8;          // address field lsb
  localparam int          DATA_HI    = 7;          // data field msb
  localparam int          NUM_WIPERS = 4;          // latches behind the link
  localparam logic [7:0]  MIDSCALE   = 8'h80;      // midscale preset code
  // ----------------------------------------------------------------
  // register map, byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFS_WIPER0 = 5'h00;      // first wiper, next ones every word
  localparam logic [4:0]  OFS_STATUS = 5'h10;      // read-only status word
  localparam logic [2:0]  IDX_STATUS = 3'h4;       // decoded index of status
  localparam logic [2:0]  IDX_NONE   = 3'h7;       // decoded index of a hole
  // status field positions
  localparam int          ST_PD      = 0;          // shutdown in force
  localparam int          ST_MID     = 1;          // midscale reset held
  localparam int          ST_SEL     = 2;          // frame open
  localparam int          ST_CNT_LO  = 4;          // bit counter lsb
  // ----------------------------------------------------------------
  // bus answers and pin idle levels
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY  = 2'h0;       // normal answer
  localparam logic [1:0]  RESP_SLVERR = 2'h2;      // unmapped address
  localparam logic [4:0]  PIN_IDLE   = 5'h0b;      // sclk,sel_n,din,mid_n,pd_n
endpackage : wiper_pkg

// >>> sync_two_ff.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int                 WIDTH   = 1,       // number of pins
  parameter logic [WIDTH-1:0]   RST_VAL = '0       // idle level after reset
) (
  input  wire logic             sys_clk,           // system clock
  input  wire logic             srst,              // synchronous reset
  input  wire logic [WIDTH-1:0] d,                 // raw pin levels
  output logic      [WIDTH-1:0] q                  // synchronised levels
);
  // ----------------------------------------------------------------
  // capture stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;                        // first stage, read by q only

  // two stages; nothing but the second stage looks at the first
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync_two_ff

// >>> serial_quad_wiper_latch_loader.sv
// quad wiper latch loader: 3-wire serial input, daisy-chain output, axi4-lite view
//
// Behaviour
// - shift serial_in on serial clock rise while selected
// - select rising commits data to addressed latch
// - address 00,01,10,11 picks latch one to four
// - midscale reset low forces all latches to 80
// - shutdown low powers down all, opens terminal a
// - serial output only pulls low or releases
// - word is two address then eight data bits
// - shutdown keeps latches, takes writes, silences output
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module serial_quad_wiper_latch_loader #(
  parameter int ADDR_W = 5                         // axi address width
) (
  input  wire logic              sys_clk,          // 250 mhz system clock
  input  wire logic              srst,             // synchronous reset, active high
  // serial link pins
  input  wire logic              serial_clk,       // serial clock pin
  input  wire logic              select_n,         // device select, active low
  input  wire logic              serial_in,        // serial data pin
  output logic                   serial_out_open_drain_o,    // always low level
  output logic                   serial_out_open_drain_oe_n, // low = pulling low
  input  wire logic              midscale_reset_n, // midscale reset, active low
  input  wire logic              power_down_n,     // shutdown, active low
  // channel outputs
  output logic [7:0]             wiper_one,        // latch one code
  output logic [7:0]             wiper_two,        // latch two code
  output logic [7:0]             wiper_three,      // latch three code
  output logic [7:0]             wiper_four,       // latch four code
  output logic                   power_down_o,     // all channels powered down
  output logic [3:0]             terminal_a_open,  // terminal a open per channel
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [4:0]        pins_s;                       // synchronised pin group
  logic              sclk_s;                       // serial clock, synced
  logic              sel_n_s;                      // select, synced
  logic              din_s;                        // serial data, synced
  logic              mid_n_s;                      // midscale reset, synced
  logic              pd_n_s;                       // shutdown, synced
  logic              sclk_d_r;                     // serial clock one cycle back
  logic              sel_n_d_r;                    // select one cycle back
  logic              sclk_rise;                    // serial clock rising edge
  logic              commit;                       // select rising edge
  logic [9:0]        shift_r;                      // serial shift register
  logic [3:0]        bit_cnt_r;                    // bits seen this frame, saturating
  logic [7:0]        wiper_r [4];                  // the four latches
  logic              pd_r;                         // registered shutdown state
  logic              aw_held_r;                    // write address captured
  logic [ADDR_W-1:0] awaddr_r;                     // captured write address
  logic              w_held_r;                     // write data captured
  logic [31:0]       wdata_r;                      // captured write data
  logic              wstrb0_r;                     // low byte lane enabled
  logic              wr_fire;                      // both halves present, do write
  logic [2:0]        wr_idx;                       // decoded write target
  logic [2:0]        rd_idx;                       // decoded read target

  // ----------------------------------------------------------------
  // address decode, shared by the write and read paths
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = wiper_pkg::IDX_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[4:2] < 3'(wiper_pkg::NUM_WIPERS)) begin
        idx = a[4:2];                              // wiper words
      end else if (a == wiper_pkg::OFS_STATUS) begin
        idx = wiper_pkg::IDX_STATUS;
      end
    end
    return idx;
  endfunction : reg_index

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  sync_two_ff #(
    .WIDTH   (5),
    .RST_VAL (wiper_pkg::PIN_IDLE)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       ({serial_clk, select_n, serial_in, midscale_reset_n, power_down_n}),
    .q       (pins_s)
  );

  assign {sclk_s, sel_n_s, din_s, mid_n_s, pd_n_s} = pins_s;

  // previous levels; edges are only seen on the synced copies
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_d_r  <= 1'b0;
      sel_n_d_r <= 1'b1;
    end else begin
      sclk_d_r  <= sclk_s;
      sel_n_d_r <= sel_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign commit    = sel_n_s & ~sel_n_d_r;         // select going high ends the word

  // ----------------------------------------------------------------
  // serial shift register
  // ----------------------------------------------------------------
  // shifting keeps going in shutdown; only the output is silenced
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shift_r <= '0;
    end else if (sclk_rise && !sel_n_s) begin
      shift_r <= {shift_r[8:0], din_s};            // msb first, address then data
    end
  end

  // bit counter for status; longer words simply pass on down the chain
  always_ff @(posedge sys_clk) begin
    if (srst || sel_n_s) begin
      bit_cnt_r <= '0;
    end else if (sclk_rise && bit_cnt_r < 4'(wiper_pkg::WORD_BITS)) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;               // saturates at one word
    end
  end

  // ----------------------------------------------------------------
  // wiper latches
  // ----------------------------------------------------------------
  // midscale beats everything; serial commit beats a bus write
  generate
    for (genvar i = 0; i < wiper_pkg::NUM_WIPERS; i++) begin : g_latch
      always_ff @(posedge sys_clk) begin
        if (srst || !mid_n_s) begin
          wiper_r[i] <= wiper_pkg::MIDSCALE;       // forced while reset pin low
        end else if (commit && shift_r[wiper_pkg::ADDR_HI:wiper_pkg::ADDR_LO] == 2'(i)) begin
          wiper_r[i] <= shift_r[wiper_pkg::DATA_HI:0]; // addressed latch only
        end else if (wr_fire && wr_idx == 3'(i) && wstrb0_r) begin
          wiper_r[i] <= wdata_r[7:0];              // software load of one latch
        end
      end
    end
  endgenerate

  assign wiper_one   = wiper_r[0];
  assign wiper_two   = wiper_r[1];
  assign wiper_three = wiper_r[2];
  assign wiper_four  = wiper_r[3];

  // ----------------------------------------------------------------
  // shutdown and serial output
  // ----------------------------------------------------------------
  // shutdown gates the channels and releases the serial output; latch contents stay put
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= ~pd_n_s;                             // one input for all channels
    end
  end

  assign power_down_o    = pd_r;
  assign terminal_a_open = {4{pd_r}};              // terminal a opened in shutdown

  // the pin is never driven high: low level, enable decides
  assign serial_out_open_drain_o    = 1'b0;
  // pull low for a zero in the last stage, release otherwise and in shutdown
  assign serial_out_open_drain_oe_n = pd_r | shift_r[wiper_pkg::ADDR_HI];

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign wr_fire       = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_idx        = reg_index(awaddr_r);

  // address and data are caught in either order, one write at a time
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid && !aw_held_r) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && !w_held_r) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb0_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // write response; status accepts and ignores writes, holes answer slverr
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= wiper_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_idx == wiper_pkg::IDX_NONE) ? wiper_pkg::RESP_SLVERR
                                                      : wiper_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx        = reg_index(s_axi_araddr);

  // read data is registered; one read in flight at most
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= wiper_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= wiper_pkg::RESP_OKAY;
      if (rd_idx < 3'(wiper_pkg::NUM_WIPERS)) begin
        s_axi_rdata[7:0] <= wiper_r[rd_idx[1:0]];
      end else if (rd_idx == wiper_pkg::IDX_STATUS) begin
        s_axi_rdata[wiper_pkg::ST_PD]  <= pd_r;
        s_axi_rdata[wiper_pkg::ST_MID] <= ~mid_n_s;
        s_axi_rdata[wiper_pkg::ST_SEL] <= ~sel_n_s;
        s_axi_rdata[wiper_pkg::ST_CNT_LO +: 4] <= bit_cnt_r;
      end else begin
        s_axi_rresp <= wiper_pkg::RESP_SLVERR;     // unmapped hole
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  shift_in_a: assert property (
    sclk_rise && !sel_n_s |=> shift_r == {$past(shift_r[8:0]), $past(din_s)})
    else $error("shift register did not take the serial bit");

  commit_data_a: assert property (
    commit && mid_n_s |=> wiper_r[$past(shift_r[9:8])] == $past(shift_r[7:0]))
    else $error("commit did not load the addressed latch");

  addr_four_a: assert property (
    commit && mid_n_s && !wr_fire && shift_r[9:8] == 2'h3
    |=> wiper_four == $past(shift_r[7:0]) && $stable(wiper_one)
        && $stable(wiper_two) && $stable(wiper_three))
    else $error("address 11 did not pick only latch four");

  midscale_a: assert property (
    !mid_n_s |=> wiper_one == 8'h80 && wiper_two == 8'h80
                 && wiper_three == 8'h80 && wiper_four == 8'h80)
    else $error("midscale reset did not force the latches");

  shutdown_pins_a: assert property (
    $fell(pd_n_s) |=> power_down_o && terminal_a_open == 4'hf)
    else $error("shutdown did not reach every channel");

  open_drain_a: assert property (
    !serial_out_open_drain_oe_n |-> serial_out_open_drain_o == 1'b0)
    else $error("serial output driven high");

  word_count_a: assert property (
    sclk_rise && !sel_n_s && bit_cnt_r < 4'ha |=> bit_cnt_r == $past(bit_cnt_r) + 4'h1)
    else $error("bit counter missed a serial bit");

  shutdown_keep_a: assert property (
    pd_r && !commit && !wr_fire && mid_n_s |-> serial_out_open_drain_oe_n
    ##1 ($stable(wiper_one) && $stable(wiper_four)))
    else $error("shutdown lost a latch or drove the output");

  chain_tail_a: assert property (
    !pd_r && pd_n_s && sclk_rise && !sel_n_s
    |=> serial_out_open_drain_oe_n == $past(shift_r[8]))
    else $error("serial output is not the last stage");
endmodule : serial_quad_wiper_latch_loader

// >>> serial_host_model.sv
// host-side model of the 3-wire serial controller
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic sys_clk,     // system clock, paces the model only
  output logic      serial_clk,  // link clock, still between frames
  output logic      select_n,    // device select, active low
  output logic      serial_in    // serial data towards the device
);
  // ------------------------------------------------------------
  // idle pin levels
  // ------------------------------------------------------------
  initial begin
    serial_clk = 1'b0;
    select_n   = 1'b1;
    serial_in  = 1'b0;
  end
  // wait n system clock edges
  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : edges
  // send the low nbits of word, msb first; half sets the link speed
  task automatic send(input logic [15:0] word, input int nbits, input int half);
    edges(1);
    select_n <= 1'b0;                 // held low for the whole word
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in <= word[i];           // address bits, then data, msb first
      edges(half);
      serial_clk <= 1'b1;
      edges(half);
      serial_clk <= 1'b0;             // data only changes while the clock is low
    end
    edges(half);
    select_n <= 1'b1;                 // rising select commits the word
    edges(1);
    serial_in <= ~serial_in;          // no longer held: hide the last value
  endtask : send
endmodule : serial_host_model

// >>> tb_serial_quad_wiper_latch_loader.sv
// self-checking bench for the quad wiper latch loader
`timescale 1ns/10ps
module tb_serial_quad_wiper_latch_loader;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        sys_clk = 1'b0;       // 250 mhz clock
  logic        srst    = 1'b1;       // synchronous reset
  logic        mid_n   = 1'b1;       // midscale reset pin
  logic        pd_n    = 1'b1;       // shutdown pin
  logic        sclk, sel_n, din;     // link pins from the host model
  logic        chain_lvl, chain_oe_n; // open drain output halves
  logic        chain_line;           // resolved chain output
  logic [7:0]  wip [4];              // wiper codes by index
  logic        pd_o;                 // power down output
  logic [3:0]  ta_open;              // terminal a open flags
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  exp_w [4];            // expected wiper codes
  logic [31:0] rd;                   // read data from the bus task
  logic [1:0]  rsp;                  // response from the bus tasks
  int          n_errors = 0;         // mismatches seen
  int          total_checks = 0;     // comparisons made
  int          cycles = 0;           // timeout counter
  // one serial frame and the latch it should change
  typedef struct { logic [15:0] word; int nbits; int idx; logic [7:0] code; } frame_row_s;
  frame_row_s rows [6] = '{'{16'h00a5, 10, 0, 8'ha5}, '{16'h015a, 10, 1, 8'h5a},
                           '{16'h02ff, 10, 2, 8'hff}, '{16'h0300, 10, 3, 8'h00},
                           '{16'h0b5a, 12, 3, 8'h5a}, '{16'h0001, 10, 0, 8'h01}};
  // pull-up: a released output reads high
  assign chain_line = chain_oe_n ? 1'b1 : chain_lvl;
  always #2 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  serial_host_model host_u (.sys_clk(sys_clk), .serial_clk(sclk), .select_n(sel_n),
                            .serial_in(din));
  serial_quad_wiper_latch_loader #(.ADDR_W(5)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .serial_clk(sclk), .select_n(sel_n), .serial_in(din),
    .serial_out_open_drain_o(chain_lvl), .serial_out_open_drain_oe_n(chain_oe_n),
    .midscale_reset_n(mid_n), .power_down_n(pd_n), .wiper_one(wip[0]), .wiper_two(wip[1]),
    .wiper_three(wip[2]), .wiper_four(wip[3]), .power_down_o(pd_o), .terminal_a_open(ta_open),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ------------------------------------------------------------
  // compare and report tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // vector compare, case equality so unknowns never match
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // single bit compare
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // all four latches against the model
  task automatic check_all();
    for (int i = 0; i < 4; i++) chk_val({24'h0, wip[i]}, {24'h0, exp_w[i]});
  endtask : check_all
  // ------------------------------------------------------------
  // axi4-lite master: hold each channel until its own handshake
  // ------------------------------------------------------------
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    r = 2'h3;
    aw_done = 0;
    w_done = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (!aw_done && awready) begin aw_done = 1; awvalid <= 1'b0; end
      if (!w_done && wready) begin w_done = 1; wvalid <= 1'b0; end
      if (bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
    @(posedge sys_clk);
  endtask : axi_write
  // read one word; returns data and response
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_done;
    ar_done = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (!ar_done && arready) begin ar_done = 1; arvalid <= 1'b0; end
      if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
    end
    @(posedge sys_clk);
  endtask : axi_read
  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) exp_w[i] = wiper_pkg::MIDSCALE;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check_all();
    chk_bit(pd_o, 1'b0);
    chk_val({28'h0, ta_open}, 32'h0);
    chk_bit(chain_line, 1'b0);
    // frames from the table at the 80 ns link period, one with two extra leading bits
    foreach (rows[r]) begin
      host_u.send(rows[r].word, rows[r].nbits, 10);
      repeat (10) @(posedge sys_clk);
      exp_w[rows[r].idx] = rows[r].code;
      check_all();
      chk_bit(chain_line, rows[r].word[9]);
    end
    // latches seen over the bus, then bus write and unmapped place
    for (int i = 0; i < 4; i++) begin
      axi_read(5'(i * 4), rd, rsp);
      chk_val(rd, {24'h0, exp_w[i]});
    end
    axi_write(5'h04, 32'h33, rsp);
    chk_val({30'h0, rsp}, {30'h0, wiper_pkg::RESP_OKAY});
    exp_w[1] = 8'h33;
    check_all();
    axi_write(5'h14, 32'h44, rsp);
    chk_val({30'h0, rsp}, {30'h0, wiper_pkg::RESP_SLVERR});
    check_all();
    axi_read(5'h14, rd, rsp);
    chk_val({rd[29:0], rsp}, {30'h0, wiper_pkg::RESP_SLVERR});
    // shutdown: output released, latches still take writes
    pd_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk_bit(pd_o, 1'b1);
    chk_val({28'h0, ta_open}, 32'hf);
    chk_bit(chain_line, 1'b1);
    host_u.send(16'h00c3, 10, 10);
    repeat (10) @(posedge sys_clk);
    exp_w[0] = 8'hc3;
    check_all();
    chk_bit(chain_line, 1'b1);
    axi_read(wiper_pkg::OFS_STATUS, rd, rsp);
    chk_val(rd & 32'h7, 32'h1);
    pd_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk_bit(pd_o, 1'b0);
    chk_bit(chain_line, 1'b0);
    check_all();
    // midscale reset wins over a commit made while it is held
    mid_n <= 1'b0;
    for (int i = 0; i < 4; i++) exp_w[i] = wiper_pkg::MIDSCALE;
    repeat (8) @(posedge sys_clk);
    check_all();
    host_u.send(16'h0177, 10, 10);
    repeat (10) @(posedge sys_clk);
    check_all();
    mid_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check_all();
    // mid-run reset: a loaded latch and a high chain bit must fall back
    host_u.send(16'h0212, 10, 10);
    repeat (10) @(posedge sys_clk);
    exp_w[2] = 8'h12;
    check_all();
    chk_bit(chain_line, 1'b1);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) exp_w[i] = wiper_pkg::MIDSCALE;
    repeat (2) @(posedge sys_clk);
    check_all();
    chk_bit(chain_line, 1'b0);
    stop_test();
  end
endmodule : tb_serial_quad_wiper_latch_loader
